// ### flpa_fifo.sv
// Small request queue with valid and ready on both sides
`timescale 1ns/1ns
module flpa_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] slots;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } flpa_fifo_t;
    flpa_fifo_t st_r;
    flpa_fifo_t st_nxt;
    logic       push;
    logic       pop;

    // Honest full and empty flags
    assign in_ready  = st_r.cnt != (AW+1)'(D);
    assign out_valid = st_r.cnt != '0;
    assign out_data  = st_r.slots[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.slots[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop)
            st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule

// ### flpa_mem.sv
// Byte array for the data memory, registered read port
`timescale 1ns/1ns
module flpa_mem (
    // Clock
    input  wire logic                        clock,
    // Write port
    input  wire logic                        wr_en,
    input  wire logic [flpa_pkg::MEM_AW-1:0] wr_addr,
    input  wire logic [7:0]                  wr_data,
    // Read port
    input  wire logic [flpa_pkg::MEM_AW-1:0] rd_addr,
    output logic [7:0]                       rd_data
);
    logic [7:0] cells_r [flpa_pkg::MEM_DEPTH];

    // Write and registered read
    always_ff @(posedge clock)
    begin
        if (wr_en)
            cells_r[wr_addr] <= wr_data;
        rd_data <= cells_r[rd_addr];
    end
endmodule

// ### flpa_pkg.sv
// Constants, encodings and types shared by the programming access block
package flpa_pkg;
    // Parallel command codes
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
    localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
    localparam logic [7:0] CMD_RD_SIG     = 8'h08;
    localparam logic [7:0] CMD_RST        = 8'h00;
    // Action select codes
    localparam logic [1:0] ACT_ADDR = 2'b00;
    localparam logic [1:0] ACT_DATA = 2'b01;
    localparam logic [1:0] ACT_CMD  = 2'b10;
    // Serial instruction bytes
    localparam logic [7:0] SER_PE_B1   = 8'hac;
    localparam logic [7:0] SER_PE_B2   = 8'h53;
    localparam logic [2:0] SER_CE_TOP  = 3'h4;
    localparam logic [7:0] SER_RD_EE   = 8'ha0;
    localparam logic [7:0] SER_WR_EE   = 8'hc0;
    localparam logic [4:0] BIT_B3_END  = 5'h17;
    localparam logic [4:0] BIT_RD      = 5'h18;
    localparam logic [4:0] BIT_LAST    = 5'h1f;
    localparam logic [2:0] BYTE_END    = 3'h7;
    // Reset contents of the configuration bytes
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [7:0] LOCK_RST    = 8'hff;
    localparam logic [7:0] ERASED      = 8'hff;
    // Identity bytes, values arbitrary
    localparam logic [7:0] SIG0 = 8'h5a;
    localparam logic [7:0] SIG1 = 8'h01;
    localparam logic [7:0] SIG2 = 8'h02;
    localparam logic [7:0] CAL  = 8'h80;
    localparam logic [7:0] SIG_ADDR0 = 8'h00;
    localparam logic [7:0] SIG_ADDR1 = 8'h01;
    localparam logic [7:0] SIG_ADDR2 = 8'h02;
    // Timing in ns and derived cycle counts
    localparam int CLK_NS      = 8;
    localparam int T_WR_MIN_NS = 3700000;
    localparam int T_WR_MAX_NS = 4500000;
    localparam int T_CE_MIN_NS = 7500000;
    localparam int T_CE_MAX_NS = 9000000;
    localparam int T_RB_MAX_NS = 1000;
    localparam int CNT_W       = 21;
    function automatic int cyc_ceil(input int t_ns);
        return (t_ns + CLK_NS - 1) / CLK_NS;
    endfunction
    localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(cyc_ceil(T_WR_MIN_NS));
    localparam logic [CNT_W-1:0] CE_CYC = CNT_W'(cyc_ceil(T_CE_MIN_NS));
    localparam int RB_CYC = T_RB_MAX_NS / CLK_NS;
    // Memory and queue geometry
    localparam int MEM_AW     = 4;
    localparam int MEM_DEPTH  = 16;
    localparam int FIFO_DEPTH = 4;
    localparam logic [1:0] OP_ERASE = 2'b00;
    localparam logic [1:0] OP_EE_WR = 2'b01;
    localparam int REQ_W = 2 + MEM_AW + 8;
    // Pin bundle positions
    localparam int PIN_W  = 18;
    localparam int P_RSTN = 17;
    localparam int P_SCK  = 16;
    localparam int P_MOSI = 15;
    localparam int P_LD   = 14;
    localparam int P_WRN  = 13;
    localparam int P_OEN  = 12;
    localparam int P_BS1  = 11;
    localparam int P_BS2  = 10;
    localparam int P_ACT  = 8;
    // Write engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CLEAR = 2'b01,
        ST_STORE = 2'b11,
        ST_WAIT  = 2'b10
    } flpa_state_t;
endpackage

// ### flpa_prog_model.sv
// Serial programmer model on the link pins
`timescale 1ns/1ns
module flpa_prog_model (
    // Clock and link pins
    input  wire logic clock,
    output logic      sck,
    output logic      mosi,
    input  wire logic miso
);
    // Link clock idles low between frames
    initial {sck, mosi} = 2'b01;
    // Shift one instruction MSB first, 10 clocks per phase
    task automatic xfer(input logic [31:0] ins, output logic [31:0] got);
        for (int i = 31; i >= 0; i--)
        begin
            mosi <= ins[i];
            repeat (10) @(posedge clock);
            got = {got[30:0], miso};
            sck <= 1'b1;
            repeat (10) @(posedge clock);
            sck <= 1'b0;
        end
        mosi <= ~ins[0]; // Idle line shows no stale bit
        // One edge apart so a following frame never drives mosi twice at once
        @(posedge clock);
    endtask
endmodule

// ### flpa_top.sv
// Fuse, lock and identity access over parallel pins, data memory access over serial link
`timescale 1ns/1ns
module flpa_top #(
    parameter logic [flpa_pkg::CNT_W-1:0] WR_CYCLES = flpa_pkg::WR_CYC,
    parameter logic [flpa_pkg::CNT_W-1:0] CE_CYCLES = flpa_pkg::CE_CYC
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Parallel programming pins
    input  wire logic [1:0] action_select,
    input  wire logic       byte_select_one,
    input  wire logic       byte_select_two,
    input  wire logic       load_strobe,
    input  wire logic       prog_strobe_n,
    input  wire logic       out_enable_n,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe_n,
    output logic            ready_busy_flag,
    // Serial programming pins
    input  wire logic       reset_pin_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso
);
    typedef struct packed {
        logic [flpa_pkg::PIN_W-1:0]  s1;
        logic [flpa_pkg::PIN_W-1:0]  s2;
        logic [flpa_pkg::PIN_W-1:0]  s3;
        logic [flpa_pkg::PIN_W-1:0]  flt;
        flpa_pkg::flpa_state_t       st;
        logic                        ers;
        logic [7:0]                  cmd;
        logic [7:0]                  addr_lo;
        logic [7:0]                  data_lo;
        logic [7:0]                  fuse_lo;
        logic [7:0]                  fuse_hi;
        logic [7:0]                  lock;
        logic [flpa_pkg::CNT_W-1:0]  tmr;
        logic [flpa_pkg::MEM_AW-1:0] ptr;
        logic [7:0]                  wdat;
        logic                        rdy;
        logic [7:0]                  dout;
        logic                        doe_n;
        logic                        prog_en;
        logic [31:0]                 sh;
        logic [4:0]                  bits;
        logic [7:0]                  osh;
        logic                        miso;
        logic                        pend;
        logic [flpa_pkg::REQ_W-1:0]  req;
        logic [flpa_pkg::MEM_AW-1:0] raddr;
    } flpa_regs_t;

    flpa_regs_t                  st_r;
    flpa_regs_t                  st_nxt;
    logic [flpa_pkg::PIN_W-1:0]  pins;
    logic [flpa_pkg::PIN_W-1:0]  flt_nxt;
    logic [flpa_pkg::PIN_W-1:0]  rise;
    logic [flpa_pkg::PIN_W-1:0]  fall;
    logic                        ser_mode;
    logic                        par_cmd_ok;
    logic                        par_start;
    logic                        rd_cmd;
    logic                        q_in_ready;
    logic                        q_out_valid;
    logic                        q_out_ready;
    logic [flpa_pkg::REQ_W-1:0]  q_out_data;
    logic                        mem_we;
    logic [7:0]                  mem_wdata;
    logic [7:0]                  mem_rdata;
    logic [31:0]                 word;

    // Pin bundle and the filtered view of it
    assign pins = {reset_pin_n, sck, mosi, load_strobe, prog_strobe_n, out_enable_n,
                   byte_select_one, byte_select_two, action_select, data_in};
    assign flt_nxt = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) | (st_r.flt & (st_r.s2 ^ st_r.s3));
    assign rise = flt_nxt & ~st_r.flt;
    assign fall = ~flt_nxt & st_r.flt;
    assign ser_mode = ~st_r.flt[flpa_pkg::P_RSTN];

    // Parallel start of a self-timed operation
    assign par_cmd_ok = (st_r.cmd == flpa_pkg::CMD_WR_FUSE && !st_r.flt[flpa_pkg::P_BS2])
                     || st_r.cmd == flpa_pkg::CMD_WR_LOCK
                     || st_r.cmd == flpa_pkg::CMD_CHIP_ERASE;
    assign par_start = fall[flpa_pkg::P_WRN] && st_r.st == flpa_pkg::ST_IDLE
                    && !ser_mode && par_cmd_ok;
    assign rd_cmd = st_r.cmd == flpa_pkg::CMD_RD_FUSE || st_r.cmd == flpa_pkg::CMD_RD_SIG;

    // Queue drains only while idle and no parallel start wins the cycle
    assign q_out_ready = (st_r.st == flpa_pkg::ST_IDLE) && !par_start;
    assign word = {st_r.sh[30:0], st_r.flt[flpa_pkg::P_MOSI]};

    // Array write port
    assign mem_we = st_r.st == flpa_pkg::ST_CLEAR || st_r.st == flpa_pkg::ST_STORE;
    assign mem_wdata = (st_r.st == flpa_pkg::ST_CLEAR) ? flpa_pkg::ERASED : st_r.wdat;

    // Outputs straight from flops
    assign data_out = st_r.dout;
    assign data_oe_n = st_r.doe_n;
    assign ready_busy_flag = st_r.rdy;
    assign miso = st_r.miso;

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // Three-stage synchronisers, change taken when stages two and three agree
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.flt = flt_nxt;

        // Load strobe latches command, address or data
        if (rise[flpa_pkg::P_LD] && !st_r.flt[flpa_pkg::P_BS1])
        begin
            if (st_r.flt[flpa_pkg::P_ACT +: 2] == flpa_pkg::ACT_CMD)
                st_nxt.cmd = st_r.flt[7:0];
            else if (st_r.flt[flpa_pkg::P_ACT +: 2] == flpa_pkg::ACT_DATA)
                st_nxt.data_lo = st_r.flt[7:0];
            else if (st_r.flt[flpa_pkg::P_ACT +: 2] == flpa_pkg::ACT_ADDR)
                st_nxt.addr_lo = st_r.flt[7:0];
        end

        // Parallel write or erase start
        if (par_start)
        begin
            st_nxt.st = flpa_pkg::ST_WAIT;
            st_nxt.tmr = WR_CYCLES;
            st_nxt.ers = 1'b0;
            if (st_r.cmd == flpa_pkg::CMD_WR_FUSE && st_r.flt[flpa_pkg::P_BS1])
                st_nxt.fuse_hi = st_r.data_lo;
            else if (st_r.cmd == flpa_pkg::CMD_WR_FUSE)
                st_nxt.fuse_lo = st_r.data_lo;
            else if (st_r.cmd == flpa_pkg::CMD_WR_LOCK)
                st_nxt.lock = st_r.lock & st_r.data_lo;
            else
            begin
                st_nxt.st = flpa_pkg::ST_CLEAR;
                st_nxt.tmr = CE_CYCLES;
                st_nxt.ers = 1'b1;
                st_nxt.ptr = '0;
            end
        end
        else if (q_out_valid && q_out_ready)
        begin
            st_nxt.st = flpa_pkg::ST_CLEAR;
            st_nxt.ptr = q_out_data[8 +: flpa_pkg::MEM_AW];
            st_nxt.wdat = q_out_data[7:0];
            st_nxt.ers = q_out_data[flpa_pkg::REQ_W-1 -: 2] == flpa_pkg::OP_ERASE;
            st_nxt.tmr = st_nxt.ers ? CE_CYCLES : WR_CYCLES;
            if (st_nxt.ers)
                st_nxt.ptr = '0;
        end

        // Write engine; timer runs in every busy state
        if (st_r.st != flpa_pkg::ST_IDLE)
            st_nxt.tmr = st_r.tmr - 1'b1;
        case (st_r.st)
            flpa_pkg::ST_CLEAR:
            begin
                if (!st_r.ers)
                    st_nxt.st = flpa_pkg::ST_STORE;
                else if (st_r.ptr == flpa_pkg::MEM_AW'(flpa_pkg::MEM_DEPTH - 1))
                begin
                    st_nxt.st = flpa_pkg::ST_WAIT;
                    st_nxt.lock = flpa_pkg::LOCK_RST;
                end
                else
                    st_nxt.ptr = st_r.ptr + 1'b1;
            end
            flpa_pkg::ST_STORE:
                st_nxt.st = flpa_pkg::ST_WAIT;
            flpa_pkg::ST_WAIT:
                if (st_r.tmr == flpa_pkg::CNT_W'(1))
                    st_nxt.st = flpa_pkg::ST_IDLE;
            default:
                ;
        endcase
        st_nxt.rdy = st_nxt.st == flpa_pkg::ST_IDLE;

        // Parallel read mux, bus driven only during a read with enable low
        st_nxt.doe_n = !(rd_cmd && !st_r.flt[flpa_pkg::P_OEN]);
        st_nxt.dout = flpa_pkg::ERASED;
        if (st_r.cmd == flpa_pkg::CMD_RD_FUSE)
        begin
            if (!st_r.flt[flpa_pkg::P_BS1] && !st_r.flt[flpa_pkg::P_BS2])
                st_nxt.dout = st_r.fuse_lo;
            else if (st_r.flt[flpa_pkg::P_BS1] && st_r.flt[flpa_pkg::P_BS2])
                st_nxt.dout = st_r.fuse_hi;
            else if (st_r.flt[flpa_pkg::P_BS1])
                st_nxt.dout = st_r.lock;
        end
        else if (st_r.flt[flpa_pkg::P_BS1])
            st_nxt.dout = flpa_pkg::CAL;
        else if (st_r.addr_lo == flpa_pkg::SIG_ADDR0)
            st_nxt.dout = flpa_pkg::SIG0;
        else if (st_r.addr_lo == flpa_pkg::SIG_ADDR1)
            st_nxt.dout = flpa_pkg::SIG1;
        else if (st_r.addr_lo == flpa_pkg::SIG_ADDR2)
            st_nxt.dout = flpa_pkg::SIG2;

        // Queue hand-off of a pending serial request
        if (st_r.pend && q_in_ready)
            st_nxt.pend = 1'b0;

        // Serial link, active only while the reset pin is low
        if (!ser_mode)
        begin
            st_nxt.bits = '0;
            st_nxt.prog_en = 1'b0;
            st_nxt.pend = 1'b0;
        end
        else
        begin
            if (rise[flpa_pkg::P_SCK])
            begin
                st_nxt.sh = word;
                st_nxt.bits = st_r.bits + 1'b1;
                if (st_r.bits[2:0] == flpa_pkg::BYTE_END)
                    st_nxt.osh = word[7:0];
                if (st_r.bits == flpa_pkg::BIT_B3_END)
                    st_nxt.raddr = word[flpa_pkg::MEM_AW-1:0];
                if (st_r.bits == flpa_pkg::BIT_LAST)
                begin
                    if (word[31:24] == flpa_pkg::SER_PE_B1 && word[23:16] == flpa_pkg::SER_PE_B2)
                        st_nxt.prog_en = 1'b1;
                    else if (st_r.prog_en && !st_r.pend)
                    begin
                        if (word[31:24] == flpa_pkg::SER_PE_B1
                            && word[23:21] == flpa_pkg::SER_CE_TOP)
                        begin
                            st_nxt.pend = 1'b1;
                            st_nxt.req = {flpa_pkg::OP_ERASE, {(flpa_pkg::MEM_AW+8){1'b0}}};
                        end
                        else if (word[31:24] == flpa_pkg::SER_WR_EE)
                        begin
                            st_nxt.pend = 1'b1;
                            st_nxt.req = {flpa_pkg::OP_EE_WR, word[8 +: flpa_pkg::MEM_AW],
                                          word[7:0]};
                        end
                    end
                end
            end
            if (fall[flpa_pkg::P_SCK])
            begin
                if (st_r.bits == flpa_pkg::BIT_RD && st_r.sh[23:16] == flpa_pkg::SER_RD_EE)
                begin
                    st_nxt.miso = mem_rdata[7];
                    st_nxt.osh = {mem_rdata[6:0], 1'b0};
                end
                else
                begin
                    st_nxt.miso = st_r.osh[7];
                    st_nxt.osh = {st_r.osh[6:0], 1'b0};
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.st <= flpa_pkg::ST_IDLE;
            st_r.cmd <= flpa_pkg::CMD_RST;
            st_r.fuse_lo <= flpa_pkg::FUSE_LO_RST;
            st_r.fuse_hi <= flpa_pkg::FUSE_HI_RST;
            st_r.lock <= flpa_pkg::LOCK_RST;
            st_r.rdy <= 1'b1;
            st_r.doe_n <= 1'b1;
            st_r.dout <= flpa_pkg::ERASED;
        end
        else
            st_r <= st_nxt;
    end

    // Serial request queue, stalled while the engine is busy
    flpa_fifo #(
        .W (flpa_pkg::REQ_W),
        .D (flpa_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (st_r.pend),
        .in_ready  (q_in_ready),
        .in_data   (st_r.req),
        .out_valid (q_out_valid),
        .out_ready (q_out_ready),
        .out_data  (q_out_data)
    );

    // Data array
    flpa_mem u_mem (
        .clock   (clock),
        .wr_en   (mem_we),
        .wr_addr (st_r.ptr),
        .wr_data (mem_wdata),
        .rd_addr (st_r.raddr),
        .rd_data (mem_rdata)
    );

    // Busy length counter for the checks below
    logic [flpa_pkg::CNT_W-1:0] busy_cnt_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= st_r.rdy ? '0 : busy_cnt_r + 1'b1;
    end

    // Checks
    busy_low_a: assert property (@(posedge clock) disable iff (rst)
        par_start |=> !ready_busy_flag) else $error("busy not low after strobe");
    wr_len_a: assert property (@(posedge clock) disable iff (rst)
        $rose(ready_busy_flag) && !st_r.ers |-> busy_cnt_r == WR_CYCLES)
        else $error("write busy length wrong");
    ce_len_a: assert property (@(posedge clock) disable iff (rst)
        $rose(ready_busy_flag) && st_r.ers |-> busy_cnt_r == CE_CYCLES)
        else $error("erase busy length wrong");
    lock_keep_a: assert property (@(posedge clock) disable iff (rst)
        st_r.st != flpa_pkg::ST_CLEAR |=> ((~$past(st_r.lock)) & st_r.lock) == 8'h00)
        else $error("lock bit released outside erase");
    bus_release_a: assert property (@(posedge clock) disable iff (rst)
        st_r.flt[flpa_pkg::P_OEN] |=> data_oe_n) else $error("bus driven with enable high");
    fuse_hi_rd_a: assert property (@(posedge clock) disable iff (rst)
        st_r.cmd == flpa_pkg::CMD_RD_FUSE && !st_r.flt[flpa_pkg::P_OEN]
        && st_r.flt[flpa_pkg::P_BS1] && st_r.flt[flpa_pkg::P_BS2]
        |=> !data_oe_n && data_out == $past(st_r.fuse_hi)) else $error("fuse high read wrong");
    lock_rd_a: assert property (@(posedge clock) disable iff (rst)
        st_r.cmd == flpa_pkg::CMD_RD_FUSE && !st_r.flt[flpa_pkg::P_OEN]
        && st_r.flt[flpa_pkg::P_BS1] && !st_r.flt[flpa_pkg::P_BS2]
        |=> !data_oe_n && data_out == $past(st_r.lock)) else $error("lock read wrong");
    sig_rd_a: assert property (@(posedge clock) disable iff (rst)
        st_r.cmd == flpa_pkg::CMD_RD_SIG && !st_r.flt[flpa_pkg::P_OEN]
        && !st_r.flt[flpa_pkg::P_BS1] && st_r.addr_lo == flpa_pkg::SIG_ADDR2
        |=> data_out == flpa_pkg::SIG2) else $error("signature read wrong");
    pe_gate_a: assert property (@(posedge clock) disable iff (rst)
        !st_r.prog_en |-> !st_r.pend) else $error("request queued before enable");
    auto_erase_a: assert property (@(posedge clock) disable iff (rst)
        st_r.st == flpa_pkg::ST_STORE |-> $past(st_r.st) == flpa_pkg::ST_CLEAR
        && mem_wdata == st_r.wdat) else $error("store without prior erase");
    fuse_wr_c: cover property (@(posedge clock) disable iff (rst)
        par_start && st_r.cmd == flpa_pkg::CMD_WR_FUSE);
    chip_er_c: cover property (@(posedge clock) disable iff (rst)
        st_r.ers && $rose(ready_busy_flag));
    ser_wr_c: cover property (@(posedge clock) disable iff (rst)
        st_r.st == flpa_pkg::ST_STORE);
endmodule

// ### tb.sv
// Bench for the programming access block
`timescale 1ns/1ns
module tb;
    localparam int WR = 64;
    localparam int CE = 128;
    logic        clock, rst, bs1, bs2, ld, wr_n, oe_n, rpin_n, doe_n, rdy, sck, mosi, miso;
    logic [1:0]  act;
    logic [7:0]  din, dout;
    logic [31:0] got;
    logic [7:0]  sig [3] = '{flpa_pkg::SIG0, flpa_pkg::SIG1, flpa_pkg::SIG2};
    int          failures = 0, check_count = 0;
    // Device with short self-timed counts
    flpa_top #(.WR_CYCLES(21'(WR)), .CE_CYCLES(21'(CE))) i_flpa_top (.clock(clock), .rst(rst),
        .action_select(act), .byte_select_one(bs1), .byte_select_two(bs2), .load_strobe(ld),
        .prog_strobe_n(wr_n), .out_enable_n(oe_n), .data_in(din), .data_out(dout),
        .data_oe_n(doe_n), .ready_busy_flag(rdy), .reset_pin_n(rpin_n), .sck(sck),
        .mosi(mosi), .miso(miso));
    flpa_prog_model i_flpa_prog_model (.clock(clock), .sck(sck), .mosi(mosi), .miso(miso));
    // 125 MHz clock
    always #4 clock = ~clock;
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // Strobe one byte in, then read one byte out
    task automatic load(input logic [1:0] a, input logic [7:0] d);
        {act, din} <= {a, d};
        step(6);
        ld <= 1'b1;
        step(6);
        ld <= 1'b0;
        step(6);
    endtask
    task automatic rd(input logic b1, input logic b2, input logic [7:0] e);
        {bs1, bs2, oe_n} <= {b1, b2, 1'b0};
        step(8);
        chk1(doe_n, 1'b0);
        chk8(dout, e);
        {bs1, bs2, oe_n} <= 3'b001;
        step(8);
        chk1(doe_n, 1'b1);
    endtask
    // Strobe a write and time the busy period
    task automatic wr(input logic b1, input int n);
        int c;
        bs1 <= b1;
        step(6);
        wr_n <= 1'b0;
        step(8);
        wr_n <= 1'b1;
        chk1(rdy, 1'b0);
        for (c = 0; rdy !== 1'b1 && c < 1000; c++)
            step(1);
        chk1(c >= n - 8 && c <= n, 1'b1);
        bs1 <= 1'b0;
    endtask
    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        step(30000);
        failures++;
        wrap_up;
    end
    // Test sequence
    initial
    begin
        {clock, rst, bs1, bs2, ld, oe_n, wr_n, rpin_n, act, din} = 18'h11c00;
        step(20);
        rst <= 1'b0;
        step(8);
        chk1(rdy, 1'b1);
        chk1(doe_n, 1'b1);
        load(2'b10, 8'h40);
        load(2'b01, 8'h3c);
        wr(1'b1, WR);
        load(2'b01, 8'hc3);
        wr(1'b0, WR);
        load(2'b10, 8'h20);
        load(2'b01, 8'hfc);
        wr(1'b0, WR);
        load(2'b01, 8'hf3);
        wr(1'b0, WR);
        load(2'b10, 8'h04);
        rd(1'b0, 1'b0, 8'hc3);
        rd(1'b1, 1'b1, 8'h3c);
        rd(1'b1, 1'b0, 8'hf0);
        load(2'b10, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            load(2'b00, 8'(i));
            rd(1'b0, 1'b0, sig[i]);
        end
        rd(1'b1, 1'b0, flpa_pkg::CAL);
        load(2'b10, 8'h80);
        wr(1'b0, CE);
        load(2'b10, 8'h04);
        rd(1'b1, 1'b0, 8'hff);
        rpin_n <= 1'b0;
        step(8);
        i_flpa_prog_model.xfer(32'hc0000411, got);
        i_flpa_prog_model.xfer(32'hac530000, got);
        chk8(got[15:8], 8'h53);
        i_flpa_prog_model.xfer(32'ha0000400, got);
        chk8(got[7:0], 8'hff);
        i_flpa_prog_model.xfer(32'hc00003a5, got);
        step(WR + 40);
        i_flpa_prog_model.xfer(32'ha0000300, got);
        chk8(got[7:0], 8'ha5);
        i_flpa_prog_model.xfer(32'hac800000, got);
        step(CE + 40);
        i_flpa_prog_model.xfer(32'ha0000300, got);
        chk8(got[7:0], 8'hff);
        wrap_up;
    end
endmodule
